// ---- rtl/tocc_regs.svh ----
// register offsets, field positions and reset values of the trigger unit control slice
// assumes byte addressing on the 16-bit host register port
`ifndef TOCC_REGS_SVH
`define TOCC_REGS_SVH

`define TOCC_ADDR_W 12
`define TOCC_OFF_TGT_SEC_HI 12'h0226
`define TOCC_OFF_CTL_ONE 12'h0228
`define TOCC_TGT_SEC_HI_RST 16'h0000
`define TOCC_CTL_ONE_RST 16'h3C00
`define TOCC_BIT_CASCADE 15
`define TOCC_BIT_TAIL 14
`define TOCC_UPSEL_HI 13
`define TOCC_UPSEL_LO 10
`define TOCC_BIT_NOW 9
`define TOCC_BIT_NOTIFY 8
`define TOCC_CTL_LOW_MASK 16'hFF00
`define TOCC_UNITS 12
`define TOCC_UPSEL_LAST 4'h0B
`define TOCC_ITER_RST 16'h0000
`define TOCC_ITER_ONE 16'h0001

`endif

// ---- rtl/tocc_pkg.sv ----
// types shared by the trigger unit control slice
// assumes tocc_regs.svh is on the include path
package tocc_pkg;
    typedef enum logic [2:0] {
        TOCC_IDLE = 3'b001,
        TOCC_ARM = 3'b010,
        TOCC_WAIT = 3'b100
    } tocc_state_e;
endpackage : tocc_pkg

// ---- rtl/tocc_cmp_if.sv ----
// carries target time and system time to the compare module and its verdicts back
// assumes both ends run on sys_clk
interface tocc_cmp_if;
    logic [31:0] target_sec;
    logic [29:0] target_ns;
    logic [31:0] time_sec;
    logic [29:0] time_ns;
    logic reached;
    logic late;
    modport ctl (output target_sec, output target_ns, output time_sec, output time_ns, input reached, input late);
    modport cmp (input target_sec, input target_ns, input time_sec, input time_ns, output reached, output late);
endinterface : tocc_cmp_if

// ---- rtl/tocc_time_cmp.sv ----
// compares the combined seconds and nanoseconds target against the system time
// assumes all inputs are synchronous to the caller's clock; purely combinational
module tocc_time_cmp (
    tocc_cmp_if.cmp cmp
);
    function automatic logic tocc_less(input logic [31:0] a_sec, input logic [29:0] a_ns,
                                       input logic [31:0] b_sec, input logic [29:0] b_ns);
        tocc_less = {a_sec, a_ns} < {b_sec, b_ns};
    endfunction : tocc_less

    // reached once system time is at or past the target, never before
    assign cmp.reached = !tocc_less(cmp.time_sec, cmp.time_ns, cmp.target_sec, cmp.target_ns); // see RULE11
    assign cmp.late = tocc_less(cmp.target_sec, cmp.target_ns, cmp.time_sec, cmp.time_ns);
endmodule : tocc_time_cmp

// ---- rtl/tocc_unit.sv ----
// control slice of one time-triggered output unit: target seconds upper word,
// cascade control, immediate trigger and done/fault reporting
// assumes system time, peer status and host strobes are all on sys_clk
`include "tocc_regs.svh"

// What this block does
// RULE1 - hold target seconds bits 31:16 in a read/write word resetting to zero
// RULE2 - bit 15 set puts this unit into a cascade chain
// RULE3 - bit 14 set marks this unit as the chain's last link
// RULE4 - all units cascaded with no tail: ignore iteration count, repeat forever
// RULE5 - software stops an endless cascade via the per-unit soft reset bits
// RULE6 - bits 13:10, default 0xF, pick the upstream unit; codes above 0xB unused
// RULE7 - bit 9 set fires at once when target already passed, else waits; here a passed target with bit 9 clear ends in a fault and idle, not a wait
// RULE8 - bit 8 enables done and fault reporting and the interrupt request
// RULE9 - enable clears itself after firing; only the chain head is software enabled
// RULE10 - soft reset returns the unit to idle and default settings
// RULE11 - fire when system time reaches target time, never earlier
// RULE12 - in a cascade start only after the selected upstream unit completes
module tocc_unit (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // host register port
    input wire logic [`TOCC_ADDR_W-1:0] reg_addr,
    input wire logic [1:0] reg_be,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // fields held by neighbouring registers
    input wire logic unit_enable,
    input wire logic unit_soft_reset,
    input wire logic [15:0] target_seconds_low,
    input wire logic [29:0] target_ns,
    input wire logic [15:0] iteration_limit,
    input wire logic fire_interrupt_enable,
    input wire logic flag_clear,
    // system precision time
    input wire logic [31:0] sys_time_sec,
    input wire logic [29:0] sys_time_ns,
    // cascade peers, bit n is unit n+1
    input wire logic [`TOCC_UNITS-1:0] peer_done,
    input wire logic [`TOCC_UNITS-1:0] peer_cascade,
    input wire logic [`TOCC_UNITS-1:0] peer_tail,
    // unit outputs
    output logic cascade_member,
    output logic tail_member,
    output logic fire_pulse,
    output logic chain_done,
    output logic enable_clear,
    output logic fire_complete_flag,
    output logic fire_fault_flag,
    output logic irq_req
);
    typedef struct packed {
        tocc_pkg::tocc_state_e state;
        logic [15:0] target_seconds_upper_word;
        logic [15:0] unit_control_word_one;
        logic [15:0] iter_cnt;
        logic fire;
        logic done_out;
        logic en_clr;
        logic done_flag;
        logic fault_flag;
        logic [15:0] rdata;
    } tocc_state_s;

    tocc_state_s st_reg;
    tocc_state_s st_next;

    tocc_cmp_if cmp_bus ();

    tocc_time_cmp u_cmp (
        .cmp(cmp_bus.cmp)
    );

    function automatic logic [15:0] tocc_merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                               input logic [1:0] be);
        logic [15:0] merged;
        merged = old_v;
        if (be[1]) begin
            merged[15:8] = new_v[15:8];
        end
        if (be[0]) begin
            merged[7:0] = new_v[7:0];
        end
        tocc_merge = merged;
    endfunction : tocc_merge

    logic cascade_on;
    logic tail_on;
    logic [3:0] up_sel;
    logic up_done;
    logic endless;
    logic start;
    logic last_iter;
    logic late_fault;
    logic any_flag;

    assign cmp_bus.target_sec = {st_reg.target_seconds_upper_word, target_seconds_low};
    assign cmp_bus.target_ns = target_ns;
    assign cmp_bus.time_sec = sys_time_sec;
    assign cmp_bus.time_ns = sys_time_ns;

    assign cascade_on = st_reg.unit_control_word_one[`TOCC_BIT_CASCADE]; // see RULE2
    assign tail_on = st_reg.unit_control_word_one[`TOCC_BIT_TAIL]; // see RULE3
    assign up_sel = st_reg.unit_control_word_one[`TOCC_UPSEL_HI:`TOCC_UPSEL_LO];
    // unused select codes never see an upstream completion
    assign up_done = (up_sel <= `TOCC_UPSEL_LAST) && peer_done[up_sel]; // see RULE6
    assign endless = (&peer_cascade) && !(|peer_tail); // see RULE4
    // head starts from software enable, followers from their upstream unit
    assign start = unit_enable || (cascade_on && up_done); // see RULE9, RULE12
    assign last_iter = tail_on && !endless && (st_reg.iter_cnt >= iteration_limit);
    // a passed target without the immediate bit is reported, not fired
    assign late_fault = cmp_bus.late && !st_reg.unit_control_word_one[`TOCC_BIT_NOW]; // see RULE7

    always_comb begin
        st_next = st_reg;
        st_next.fire = 1'b0;
        st_next.done_out = 1'b0;
        st_next.en_clr = 1'b0;
        st_next.rdata = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                `TOCC_OFF_TGT_SEC_HI: st_next.rdata = st_reg.target_seconds_upper_word;
                `TOCC_OFF_CTL_ONE: st_next.rdata = st_reg.unit_control_word_one;
                default: st_next.rdata = 16'h0000;
            endcase
        end
        if (reg_wr && reg_addr == `TOCC_OFF_TGT_SEC_HI) begin
            st_next.target_seconds_upper_word = tocc_merge(st_reg.target_seconds_upper_word, reg_wdata, reg_be); // see RULE1
        end
        if (reg_wr && reg_addr == `TOCC_OFF_CTL_ONE) begin
            st_next.unit_control_word_one = tocc_merge(st_reg.unit_control_word_one, reg_wdata, reg_be)
                                            & `TOCC_CTL_LOW_MASK;
        end
        // a flag set in this cycle wins over a clear in the same cycle
        if (flag_clear) begin
            st_next.done_flag = 1'b0;
            st_next.fault_flag = 1'b0;
        end
        unique case (st_reg.state)
            tocc_pkg::TOCC_IDLE: begin
                if (start) begin
                    st_next.state = tocc_pkg::TOCC_ARM;
                end
            end
            tocc_pkg::TOCC_ARM: begin
                // first look at the target decides between late handling and waiting
                if (late_fault) begin
                    st_next.state = tocc_pkg::TOCC_IDLE;
                    st_next.en_clr = 1'b1;
                    st_next.fault_flag = st_reg.unit_control_word_one[`TOCC_BIT_NOTIFY] || st_next.fault_flag; // see RULE8
                end else if (cmp_bus.reached) begin
                    st_next.state = tocc_pkg::TOCC_WAIT;
                end else begin
                    st_next.state = tocc_pkg::TOCC_WAIT;
                end
            end
            tocc_pkg::TOCC_WAIT: begin
                if (cmp_bus.reached) begin // see RULE7, RULE11
                    st_next.state = tocc_pkg::TOCC_IDLE;
                    st_next.fire = 1'b1;
                    st_next.en_clr = 1'b1; // see RULE9
                    st_next.done_flag = st_reg.unit_control_word_one[`TOCC_BIT_NOTIFY] || st_next.done_flag; // see RULE8
                    if (tail_on) begin
                        if (last_iter) begin
                            st_next.iter_cnt = `TOCC_ITER_RST;
                        end else begin
                            st_next.iter_cnt = st_reg.iter_cnt + `TOCC_ITER_ONE;
                        end
                    end
                    // a tail on its final pass stops the loop; an endless chain never does
                    st_next.done_out = !last_iter; // see RULE4
                end
            end
            default: st_next.state = tocc_pkg::TOCC_IDLE;
        endcase
        if (unit_soft_reset) begin // see RULE5, RULE10
            st_next.state = tocc_pkg::TOCC_IDLE;
            st_next.target_seconds_upper_word = `TOCC_TGT_SEC_HI_RST;
            st_next.unit_control_word_one = `TOCC_CTL_ONE_RST;
            st_next.iter_cnt = `TOCC_ITER_RST;
            st_next.fire = 1'b0;
            st_next.done_out = 1'b0;
            st_next.done_flag = 1'b0;
            st_next.fault_flag = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st_reg.state <= tocc_pkg::TOCC_IDLE;
            st_reg.target_seconds_upper_word <= `TOCC_TGT_SEC_HI_RST; // see RULE1
            st_reg.unit_control_word_one <= `TOCC_CTL_ONE_RST; // see RULE6
            st_reg.iter_cnt <= `TOCC_ITER_RST;
            st_reg.fire <= 1'b0;
            st_reg.done_out <= 1'b0;
            st_reg.en_clr <= 1'b0;
            st_reg.done_flag <= 1'b0;
            st_reg.fault_flag <= 1'b0;
            st_reg.rdata <= 16'h0000;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign cascade_member = cascade_on;
    assign tail_member = tail_on;
    assign fire_pulse = st_reg.fire;
    assign chain_done = st_reg.done_out;
    assign enable_clear = st_reg.en_clr;
    assign fire_complete_flag = st_reg.done_flag;
    assign fire_fault_flag = st_reg.fault_flag;
    assign any_flag = st_reg.done_flag || st_reg.fault_flag;
    assign irq_req = fire_interrupt_enable && any_flag; // see RULE8
endmodule : tocc_unit

// ---- tb/tocc_unit_chk.sv ----
// assertions on the ports of the trigger unit control slice
// assumes it is bound onto tocc_unit, one clock domain
`include "tocc_regs.svh"
module tocc_unit_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // host side
    input wire logic [`TOCC_ADDR_W-1:0] reg_addr,
    input wire logic [1:0] reg_be,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic unit_soft_reset,
    input wire logic fire_interrupt_enable,
    input wire logic flag_clear,
    // unit outputs
    input wire logic cascade_member,
    input wire logic fire_pulse,
    input wire logic chain_done,
    input wire logic enable_clear,
    input wire logic fire_complete_flag,
    input wire logic fire_fault_flag,
    input wire logic irq_req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("stray read data");
    a_cascade_write: assert property ((reg_wr && reg_addr == `TOCC_OFF_CTL_ONE && reg_be[1] && !unit_soft_reset)
        |=> cascade_member == $past(reg_wdata[15])) else $error("cascade bit not written");
    a_pulse_single: assert property (fire_pulse |=> !fire_pulse) else $error("fire pulse too long");
    a_chain_fire: assert property (chain_done |-> fire_pulse && enable_clear) else $error("chain done alone");
    a_irq_level: assert property (irq_req == (fire_interrupt_enable && (fire_complete_flag || fire_fault_flag)))
        else $error("irq level wrong");
    a_flag_sticky: assert property (fire_complete_flag && !flag_clear && !unit_soft_reset |=> fire_complete_flag)
        else $error("done flag lost");
    a_done_fire: assert property ($rose(fire_complete_flag) |-> fire_pulse) else $error("done without fire");
    a_fault_nofire: assert property ($rose(fire_fault_flag) |-> !fire_pulse && enable_clear)
        else $error("fault path fired");
    a_soft_clear: assert property (unit_soft_reset |=> !cascade_member && !fire_pulse) else $error("soft reset");
endmodule : tocc_unit_chk
bind tocc_unit tocc_unit_chk u_chk (.sys_clk, .rst_b, .reg_addr, .reg_be, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .unit_soft_reset, .fire_interrupt_enable, .flag_clear, .cascade_member, .fire_pulse, .chain_done, .enable_clear,
    .fire_complete_flag, .fire_fault_flag, .irq_req);

// ---- tb/testbench.sv ----
// self-checking bench for the trigger unit control slice
// assumes tocc_unit and its bound checker are compiled first
`include "tocc_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, unit_enable = 0, unit_soft_reset = 0, flag_clear = 0;
    logic fire_interrupt_enable = 1, cascade_member, tail_member, fire_pulse, chain_done, enable_clear, irq_req;
    logic fire_complete_flag, fire_fault_flag;
    logic [`TOCC_ADDR_W-1:0] reg_addr = 12'h000;
    logic [11:0] peer_done = 12'h000;
    logic [1:0] reg_be = 2'b11;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [29:0] target_ns = 30'h0, sys_time_ns = 30'h0;
    int num_errors = 0, checked = 0, cycles = 0;
    tocc_unit dut (.sys_clk, .rst_b, .reg_addr, .reg_be, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .unit_enable,
        .unit_soft_reset, .target_seconds_low(16'h0000), .target_ns, .iteration_limit(16'h0000),
        .fire_interrupt_enable, .flag_clear, .sys_time_sec(32'h0000_0000), .sys_time_ns, .peer_done,
        .peer_cascade(12'h000), .peer_tail(12'h000), .cascade_member, .tail_member, .fire_pulse, .chain_done,
        .enable_clear, .fire_complete_flag, .fire_fault_flag, .irq_req);
    always #25 sys_clk = ~sys_clk;
    // free running nanosecond count stands in for system time
    always @(posedge sys_clk) begin
        sys_time_ns <= sys_time_ns + 30'h1;
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask : step
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        step();
        reg_wr = 0;
        step();
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [15:0] e, input string nm);
        reg_addr = a;
        reg_rd = 1;
        step();
        reg_rd = 0;
        chk(reg_rdata, e, nm);
        step();
    endtask : rd
    // arms the unit by enable or by upstream done, then judges the outcome
    task automatic go(input logic [15:0] ctl, input logic [29:0] tns, input logic cas, input logic efire,
                      input logic eflt);
        logic hit;
        hit = 0;
        wr(12'h228, ctl);
        target_ns = tns;
        peer_done = cas ? 12'h004 : 12'h000;
        unit_enable = !cas;
        step();
        peer_done = 12'h000;
        unit_enable = 0;
        for (int n = 0; n < 200 && !hit; n++) begin
            step();
            hit = fire_pulse | enable_clear;
        end
        chk(fire_pulse, efire, "fire");
        chk(chain_done, efire & !ctl[14], "chain done");
        chk(fire_complete_flag, efire & ctl[8], "done flag");
        chk(fire_fault_flag, eflt & ctl[8], "fault flag");
        chk(irq_req, (efire | eflt) & ctl[8] & fire_interrupt_enable, "irq");
        chk(!efire || sys_time_ns > tns, 1'b1, "not early");
        flag_clear = 1;
        step();
        flag_clear = 0;
    endtask : go
    task automatic t_regs();
        rd(12'h226, 16'h0000, "seconds reset");
        rd(12'h228, 16'h3C00, "control reset");
        rd(12'h22A, 16'h0000, "unmapped");
        wr(12'h226, 16'hA5C3);
        rd(12'h226, 16'hA5C3, "seconds word");
        wr(12'h226, 16'h0000);
        wr(12'h228, 16'hC7FF);
        rd(12'h228, 16'hC700, "control word");
        chk({cascade_member, tail_member}, 2'b11, "cascade tail");
    endtask : t_regs
    task automatic t_fire();
        go(16'h0300, 30'h0, 0, 1, 0);
        go(16'h0100, sys_time_ns + 30'h28, 0, 1, 0);
        go(16'h0100, 30'h0, 0, 0, 1);
        fire_interrupt_enable = 0;
        go(16'h0300, 30'h0, 0, 1, 0);
        fire_interrupt_enable = 1;
        go(16'h0200, 30'h0, 0, 1, 0);
        go(16'h4300, 30'h0, 0, 1, 0);
    endtask : t_fire
    task automatic t_cascade();
        go(16'h8B00, 30'h0, 1, 1, 0);
        go(16'h8300, 30'h0, 1, 0, 0);
    endtask : t_cascade
    task automatic t_soft();
        wr(12'h228, 16'hC000);
        unit_soft_reset = 1;
        step();
        unit_soft_reset = 0;
        rd(12'h228, 16'h3C00, "soft reset control");
        chk(cascade_member, 1'b0, "soft reset cascade");
    endtask : t_soft
    task automatic close_out();
        if (num_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out
    initial begin
        repeat (8) step();
        rst_b = 1;
        step();
        t_regs();
        t_fire();
        t_cascade();
        t_soft();
        close_out();
    end
endmodule : testbench
